// ==== core/cltd_pkg.sv ====
// constants, states and carriers of the control / literal / table decoder
// assumes one core clock and 16-bit words from program memory
package cltd_pkg;
  localparam logic [3:0] HI_LIT = 4'h0;
  localparam logic [3:0] HI_BRANCH = 4'hE;
  localparam logic [3:0] HI_SECOND = 4'hF;
  localparam logic [3:0] E_GOTO = 4'hF;
  localparam logic [3:0] E_LOAD_POINTER_LITERAL = 4'hE;
  localparam logic [2:0] E_CALL = 3'h6;
  localparam logic [3:0] LIT_ADD = 4'hF;
  localparam logic [3:0] LIT_SUB = 4'h8;
  localparam logic [3:0] LIT_AND = 4'hB;
  localparam logic [3:0] LIT_IOR = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'hA;
  localparam logic [3:0] LIT_MOV = 4'hE;
  localparam logic [3:0] LIT_MUL = 4'hD;
  localparam logic [3:0] LIT_RET = 4'hC;
  localparam logic [11:0] BANK_PREFIX = 12'h010;
  localparam logic [7:0] CTL_KICK = 8'h04;
  localparam logic [7:0] CTL_SLEEP = 8'h03;
  localparam logic [7:0] CTL_PUSH = 8'h05;
  localparam logic [7:0] CTL_POP = 8'h06;
  localparam logic [6:0] CTL_RETURN_FROM_ISR = 7'h08;
  localparam logic [6:0] CTL_RETURN = 7'h09;
  localparam logic [5:0] CTL_TABLE_FETCH = 6'h02;
  localparam logic [5:0] CTL_TABLE_STORE = 6'h03;
  localparam logic [1:0] TM_POST_INC = 2'h1;
  localparam logic [1:0] TM_POST_DEC = 2'h2;
  localparam logic [1:0] TM_PRE_INC = 2'h3;
  localparam logic [1:0] TBL_LONG_EXTRA = 2'h3;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WORK = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_TBLPTR = 8'h14;
  localparam logic [7:0] OFS_TABLAT = 8'h18;
  localparam logic [7:0] OFS_PROD = 8'h1C;
  localparam logic [7:0] OFS_SP = 8'h20;
  localparam logic [7:0] OFS_TOS = 8'h24;
  localparam logic [7:0] OFS_PTR0 = 8'h28;
  localparam logic [7:0] OFS_PTR1 = 8'h2C;
  localparam logic [7:0] OFS_PTR2 = 8'h30;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GIEH = 1;
  localparam int CTRL_GIEL = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cltd_flags_t;
  typedef enum logic [2:0] {
    S_EXEC, S_NOP2, S_WORD2, S_TABLE_FETCH, S_TBLWR, S_TBLLONG, S_SLEEP
  } cltd_state_t;
endpackage

// ==== core/cltd_core.sv ====
// control, literal and table-access execution for an 8-bit core
// assumes asynchronous-read program memory on FETCH_ADDR, AXI4-Lite host
`timescale 1ns/10ps
module cltd_core #(
  parameter int STACK_DEPTH = 31,
  parameter logic [11:0] TIMER_ZERO_ADDR = 12'h0F0,
  parameter logic [11:0] PORT_ADDR = 12'h0F1
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [20:0] FETCH_ADDR,
  input wire logic [15:0] FETCH_WORD,
  output logic [20:0] TBL_ADDR,
  input wire logic [7:0] TBL_RD_DATA,
  output logic [7:0] TBL_WR_DATA,
  output logic TBL_WR_STB,
  input wire logic TBL_LONG_REQ,
  output logic TBL_WR_BUSY,
  output logic WDT_CLEAR,
  output logic STANDBY,
  input wire logic WAKE,
  input wire logic FILE_WR_STB,
  input wire logic [11:0] FILE_WR_ADDR,
  input wire logic FILE_WR_DEST,
  input wire logic PRESCALER_ASSIGNED,
  output logic PRESCALER_CLEAR,
  input wire logic [11:0] RMW_ADDR,
  input wire logic [7:0] PORT_PINS,
  input wire logic [7:0] FILE_RD_DATA,
  output logic [7:0] RMW_OPERAND
);
  localparam int SPW = $clog2(STACK_DEPTH + 1);

  cltd_pkg::cltd_state_t state_reg;
  cltd_pkg::cltd_flags_t flags_reg, shadow_flags_reg, alu_flags;
  logic [20:0] pc_reg, tblptr_reg, return_stack_top;
  logic [20:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] sp_reg;
  logic [15:0] first_reg, prod_reg;
  logic [7:0] w_reg, shadow_w_reg, bank_reg, shadow_bank_reg, tablat_reg, alu_res;
  logic [11:0] ptr_reg [3];
  logic [2:0] ctrl_reg;
  logic [1:0] mode_reg, long_cnt_reg;
  logic to_reg, pd_reg, kick_reg, rmw_clr_reg;
  logic [15:0] iw;
  logic [7:0] lit;
  logic step, d_br, d_taken, d_call, d_goto, d_load_pointer_literal, d_ctl, d_lit, d_bank;
  logic d_kick, d_sleep, d_push, d_pop, d_return_from_isr, d_ret, d_return_with_literal;
  logic d_table_fetch, d_table_store, d_any_ret, stack_full, stack_empty;

  function automatic logic cond_true(input logic [2:0] cc, input cltd_pkg::cltd_flags_t f);
    logic t;
    t = 1'b0;
    case (cc[2:1])
      2'h0: t = f.z;
      2'h1: t = f.c;
      2'h2: t = f.ov;
      2'h3: t = f.n;
      default: t = 1'b0;
    endcase
    return cc[0] ? ~t : t;
  endfunction

  // pre-increment acts in the first cycle, post modes in the second
  function automatic logic [20:0] next_ptr(input logic [20:0] p, input logic [1:0] m,
                                           input logic second);
    logic [20:0] r;
    r = p;
    if (!second && m == cltd_pkg::TM_PRE_INC) begin
      r = p + 21'h000001;
    end else if (second && m == cltd_pkg::TM_POST_INC) begin
      r = p + 21'h000001;
    end else if (second && m == cltd_pkg::TM_POST_DEC) begin
      r = p - 21'h000001;
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= cltd_pkg::OFS_PTR2;
  endfunction

  assign iw = FETCH_WORD;
  assign lit = iw[7:0];
  assign step = state_reg == cltd_pkg::S_EXEC && ctrl_reg[cltd_pkg::CTRL_RUN];
  assign stack_full = sp_reg == SPW'(STACK_DEPTH);
  assign stack_empty = sp_reg == '0;
  assign return_stack_top = stack_empty ? 21'h000000 : stack_mem[sp_reg - SPW'(1)];

  // anything not matched below, including a lone 1111 word, falls to nop
  always_comb begin
    d_br = step && iw[15:12] == cltd_pkg::HI_BRANCH && !iw[11];
    d_taken = d_br && cond_true(iw[10:8], flags_reg);
    d_call = step && iw[15:12] == cltd_pkg::HI_BRANCH && iw[11:9] == cltd_pkg::E_CALL;
    d_goto = step && iw[15:12] == cltd_pkg::HI_BRANCH && iw[11:8] == cltd_pkg::E_GOTO;
    d_load_pointer_literal = step && iw[15:12] == cltd_pkg::HI_BRANCH && iw[11:8] == cltd_pkg::E_LOAD_POINTER_LITERAL
             && iw[7:6] == 2'h0;
    d_lit = step && iw[15:12] == cltd_pkg::HI_LIT;
    d_ctl = step && iw[15:8] == 8'h00;
    d_bank = step && iw[15:4] == cltd_pkg::BANK_PREFIX;
    d_kick = d_ctl && iw[7:0] == cltd_pkg::CTL_KICK;
    d_sleep = d_ctl && iw[7:0] == cltd_pkg::CTL_SLEEP;
    d_push = d_ctl && iw[7:0] == cltd_pkg::CTL_PUSH;
    d_pop = d_ctl && iw[7:0] == cltd_pkg::CTL_POP;
    d_return_from_isr = d_ctl && iw[7:1] == cltd_pkg::CTL_RETURN_FROM_ISR;
    d_ret = d_ctl && iw[7:1] == cltd_pkg::CTL_RETURN;
    d_return_with_literal = d_lit && iw[11:8] == cltd_pkg::LIT_RET;
    d_table_fetch = d_ctl && iw[7:2] == cltd_pkg::CTL_TABLE_FETCH;
    d_table_store = d_ctl && iw[7:2] == cltd_pkg::CTL_TABLE_STORE;
    d_any_ret = d_return_from_isr || d_ret || d_return_with_literal;
  end

  // one adder serves both: reverse subtract is k + ~w + 1
  always_comb begin
    logic sub;
    logic [7:0] b;
    logic [8:0] s9;
    logic [4:0] s5;
    sub = iw[11:8] == cltd_pkg::LIT_SUB;
    b = sub ? ~w_reg : w_reg;
    s9 = {1'b0, lit} + {1'b0, b} + {8'h00, sub};
    s5 = {1'b0, lit[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
    alu_flags = flags_reg;
    alu_res = w_reg;
    case (iw[11:8])
      cltd_pkg::LIT_ADD, cltd_pkg::LIT_SUB: begin
        alu_res = s9[7:0];
        alu_flags.c = s9[8];
        alu_flags.dc = s5[4];
        alu_flags.ov = (lit[7] == b[7]) && (s9[7] != lit[7]);
      end
      cltd_pkg::LIT_AND: alu_res = w_reg & lit;
      cltd_pkg::LIT_IOR: alu_res = w_reg | lit;
      cltd_pkg::LIT_XOR: alu_res = w_reg ^ lit;
      default: alu_res = w_reg;
    endcase
    alu_flags.z = alu_res == 8'h00;
    alu_flags.n = alu_res[7];
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= cltd_pkg::S_EXEC;
      long_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        cltd_pkg::S_EXEC: begin
          if (d_taken || d_any_ret) begin
            state_reg <= cltd_pkg::S_NOP2;
          end else if (d_call || d_goto || d_load_pointer_literal) begin
            state_reg <= cltd_pkg::S_WORD2;
          end else if (d_table_fetch) begin
            state_reg <= cltd_pkg::S_TABLE_FETCH;
          end else if (d_table_store) begin
            state_reg <= cltd_pkg::S_TBLWR;
          end else if (d_sleep) begin
            state_reg <= cltd_pkg::S_SLEEP;
          end
        end
        cltd_pkg::S_TBLWR: begin
          long_cnt_reg <= cltd_pkg::TBL_LONG_EXTRA - 2'h1;
          state_reg <= TBL_LONG_REQ ? cltd_pkg::S_TBLLONG : cltd_pkg::S_EXEC;
        end
        cltd_pkg::S_TBLLONG: begin
          // ignores the run bit so a memory write is never cut short
          long_cnt_reg <= long_cnt_reg - 2'h1;
          if (long_cnt_reg == 2'h0) begin
            state_reg <= cltd_pkg::S_EXEC;
          end
        end
        cltd_pkg::S_SLEEP: begin
          if (WAKE) begin
            state_reg <= cltd_pkg::S_EXEC;
          end
        end
        default: state_reg <= cltd_pkg::S_EXEC;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pc_reg <= 21'h000000;
      first_reg <= 16'h0000;
      mode_reg <= 2'h0;
    end else if (step) begin
      first_reg <= iw;
      mode_reg <= iw[1:0];
      if (d_taken) begin
        pc_reg <= pc_reg + 21'h000002 + {{12{iw[7]}}, iw[7:0], 1'b0};
      end else if (d_any_ret) begin
        pc_reg <= return_stack_top;
      end else begin
        pc_reg <= pc_reg + 21'h000002;
      end
    end else if (state_reg == cltd_pkg::S_WORD2) begin
      if (first_reg[11:8] == cltd_pkg::E_LOAD_POINTER_LITERAL) begin
        pc_reg <= pc_reg + 21'h000002;
      end else begin
        pc_reg <= {iw[11:0], first_reg[7:0], 1'b0};
      end
    end
  end

  // a full stack drops further pushes; an empty one ignores pops
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sp_reg <= '0;
    end else if (state_reg == cltd_pkg::S_WORD2 && first_reg[11:9] == cltd_pkg::E_CALL) begin
      if (!stack_full) begin
        stack_mem[sp_reg] <= pc_reg + 21'h000002;
        sp_reg <= sp_reg + SPW'(1);
      end
    end else if (d_push && !stack_full) begin
      stack_mem[sp_reg] <= pc_reg + 21'h000002;
      sp_reg <= sp_reg + SPW'(1);
    end else if ((d_pop || d_any_ret) && !stack_empty) begin
      sp_reg <= sp_reg - SPW'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      w_reg <= 8'h00;
      flags_reg <= '0;
      bank_reg <= 8'h00;
      prod_reg <= 16'h0000;
    end else if (d_lit) begin
      case (iw[11:8])
        cltd_pkg::LIT_ADD, cltd_pkg::LIT_SUB, cltd_pkg::LIT_AND,
        cltd_pkg::LIT_IOR, cltd_pkg::LIT_XOR: begin
          w_reg <= alu_res;
          flags_reg <= alu_flags;
        end
        cltd_pkg::LIT_MOV: w_reg <= lit;
        cltd_pkg::LIT_MUL: prod_reg <= lit * w_reg;
        cltd_pkg::LIT_RET: w_reg <= lit;
        default: begin
          if (d_bank) begin
            bank_reg[3:0] <= iw[3:0];
          end
          if ((d_ret || d_return_from_isr) && iw[0]) begin
            w_reg <= shadow_w_reg;
            flags_reg <= shadow_flags_reg;
            bank_reg <= shadow_bank_reg;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      shadow_w_reg <= 8'h00;
      shadow_flags_reg <= '0;
      shadow_bank_reg <= 8'h00;
    end else if (d_call && iw[8]) begin
      shadow_w_reg <= w_reg;
      shadow_flags_reg <= flags_reg;
      shadow_bank_reg <= bank_reg;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ptr_reg[0] <= 12'h000;
      ptr_reg[1] <= 12'h000;
      ptr_reg[2] <= 12'h000;
    end else if (state_reg == cltd_pkg::S_WORD2 && first_reg[11:8] == cltd_pkg::E_LOAD_POINTER_LITERAL
                 && first_reg[5:4] != 2'h3) begin
      ptr_reg[first_reg[5:4]] <= {first_reg[3:0], iw[7:0]};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
      kick_reg <= 1'b0;
    end else begin
      kick_reg <= d_kick;
      if (d_kick) begin
        to_reg <= 1'b1;
        pd_reg <= 1'b1;
      end else if (d_sleep) begin
        to_reg <= 1'b1;
        pd_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rmw_clr_reg <= 1'b0;
      RMW_OPERAND <= 8'h00;
    end else begin
      rmw_clr_reg <= FILE_WR_STB && FILE_WR_ADDR == TIMER_ZERO_ADDR
                     && FILE_WR_DEST && PRESCALER_ASSIGNED;
      RMW_OPERAND <= RMW_ADDR == PORT_ADDR ? PORT_PINS : FILE_RD_DATA;
    end
  end

  // bus slave: address and data are captured apart, then answered together
  logic aw_have_reg, w_have_reg, wr_fire;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rd_mux, wr_val;
  logic [3:0] w_strb_reg;

  assign S_AXI_AWREADY = !aw_have_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_have_reg && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= cltd_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_addr_reg) ? cltd_pkg::RESP_OKAY : cltd_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (S_AXI_ARADDR)
      cltd_pkg::OFS_CTRL: rd_mux[2:0] = ctrl_reg;
      cltd_pkg::OFS_STATUS: rd_mux[7:0] = {STANDBY, to_reg, pd_reg, flags_reg};
      cltd_pkg::OFS_WORK: rd_mux[7:0] = w_reg;
      cltd_pkg::OFS_BANK: rd_mux[7:0] = bank_reg;
      cltd_pkg::OFS_PC: rd_mux[20:0] = pc_reg;
      cltd_pkg::OFS_TBLPTR: rd_mux[20:0] = tblptr_reg;
      cltd_pkg::OFS_TABLAT: rd_mux[7:0] = tablat_reg;
      cltd_pkg::OFS_PROD: rd_mux[15:0] = prod_reg;
      cltd_pkg::OFS_SP: rd_mux[SPW-1:0] = sp_reg;
      cltd_pkg::OFS_TOS: rd_mux[20:0] = return_stack_top;
      cltd_pkg::OFS_PTR0: rd_mux[11:0] = ptr_reg[0];
      cltd_pkg::OFS_PTR1: rd_mux[11:0] = ptr_reg[1];
      cltd_pkg::OFS_PTR2: rd_mux[11:0] = ptr_reg[2];
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= cltd_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? cltd_pkg::RESP_OKAY : cltd_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  assign wr_val = merge({11'h000, aw_addr_reg == cltd_pkg::OFS_CTRL ? {18'h00000, ctrl_reg}
                         : aw_addr_reg == cltd_pkg::OFS_TABLAT ? {13'h0000, tablat_reg}
                         : tblptr_reg}, w_data_reg, w_strb_reg);

  // hardware updates win over a software write in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_reg <= cltd_pkg::CTRL_RESET;
    end else begin
      if (wr_fire && aw_addr_reg == cltd_pkg::OFS_CTRL) begin
        ctrl_reg <= wr_val[2:0];
      end
      if (d_return_from_isr) begin
        if (ctrl_reg[cltd_pkg::CTRL_GIEH]) begin
          ctrl_reg[cltd_pkg::CTRL_GIEL] <= 1'b1;
        end else begin
          ctrl_reg[cltd_pkg::CTRL_GIEH] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tblptr_reg <= 21'h000000;
      tablat_reg <= 8'h00;
    end else begin
      if (wr_fire && aw_addr_reg == cltd_pkg::OFS_TBLPTR) begin
        tblptr_reg <= wr_val[20:0];
      end
      if (wr_fire && aw_addr_reg == cltd_pkg::OFS_TABLAT) begin
        tablat_reg <= wr_val[7:0];
      end
      if (d_table_fetch || d_table_store) begin
        tblptr_reg <= next_ptr(tblptr_reg, iw[1:0], 1'b0);
      end else if (state_reg == cltd_pkg::S_TABLE_FETCH || state_reg == cltd_pkg::S_TBLWR) begin
        tblptr_reg <= next_ptr(tblptr_reg, mode_reg, 1'b1);
      end
      if (state_reg == cltd_pkg::S_TABLE_FETCH) begin
        tablat_reg <= TBL_RD_DATA;
      end
    end
  end

  assign FETCH_ADDR = pc_reg;
  assign TBL_ADDR = tblptr_reg;
  assign TBL_WR_DATA = tablat_reg;
  assign TBL_WR_STB = state_reg == cltd_pkg::S_TBLWR;
  assign TBL_WR_BUSY = state_reg == cltd_pkg::S_TBLLONG;
  assign STANDBY = state_reg == cltd_pkg::S_SLEEP;
  assign WDT_CLEAR = kick_reg;
  assign PRESCALER_CLEAR = rmw_clr_reg;
endmodule

// ==== verif/cltd_prog_mem.sv ====
// program image and table memory standing behind the decoder
// assumes asynchronous reads: the word at FETCH_ADDR shows in the same cycle
`timescale 1ns/10ps
module cltd_prog_mem (
  input wire logic [20:0] FETCH_ADDR,
  output logic [15:0] FETCH_WORD,
  input wire logic [20:0] TBL_ADDR,
  output logic [7:0] TBL_RD_DATA,
  output logic TBL_LONG_REQ
);
  // main line, then two subroutines at words 24 and 28; ends in standby and a spin
  localparam logic [15:0] IMG [0:28] = '{
    16'h0E25, 16'h0F15, 16'h0D03, 16'h0105, 16'hEE11, 16'hF0BC, 16'h0004, 16'hFFFF,
    16'h08FF, 16'h0B0F, 16'h0A05, 16'hE001, 16'h010A, 16'hE105, 16'h0009, 16'h000C,
    16'h000F, 16'hEC18, 16'hF000, 16'hEC1C, 16'hF000, 16'h0003, 16'hEF16, 16'hF000,
    16'h0005, 16'h0006, 16'h0C42, 16'h0000, 16'h0010};
  logic [19:0] idx;
  assign idx = FETCH_ADDR[20:1];
  // outside the image a lone second-word pattern, itself a nop
  assign FETCH_WORD = (idx < 20'h0001D) ? IMG[idx] : 16'hFFFF;
  assign TBL_RD_DATA = TBL_ADDR[7:0] ^ 8'h5A;
  // odd pairs of table bytes start a long memory write
  assign TBL_LONG_REQ = TBL_ADDR[1];
endmodule

// ==== verif/cltd_checker.sv ====
// port-level timing checks of the control / literal / table decoder
// assumes the single REF_CLK domain with synchronous active-high RST
`timescale 1ns/10ps
module cltd_checker #(
  parameter logic [11:0] TIMER_ZERO_ADDR = 12'h0F0,
  parameter logic [11:0] PORT_ADDR = 12'h0F1
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic TBL_WR_STB,
  input wire logic TBL_LONG_REQ,
  input wire logic TBL_WR_BUSY,
  input wire logic WDT_CLEAR,
  input wire logic STANDBY,
  input wire logic WAKE,
  input wire logic FILE_WR_STB,
  input wire logic [11:0] FILE_WR_ADDR,
  input wire logic FILE_WR_DEST,
  input wire logic PRESCALER_ASSIGNED,
  input wire logic PRESCALER_CLEAR,
  input wire logic [11:0] RMW_ADDR,
  input wire logic [7:0] PORT_PINS,
  input wire logic [7:0] FILE_RD_DATA,
  input wire logic [7:0] RMW_OPERAND
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic tz_hit;
  assign tz_hit = FILE_WR_STB && FILE_WR_ADDR == TIMER_ZERO_ADDR && FILE_WR_DEST;
  a_prescaler_clear: assert property (
    tz_hit && PRESCALER_ASSIGNED |=> PRESCALER_CLEAR) else $error("prescaler not cleared");
  a_prescaler_kept: assert property (
    !(tz_hit && PRESCALER_ASSIGNED) |=> !PRESCALER_CLEAR) else $error("stray prescaler clear");
  a_rmw_operand: assert property (
    1'b1 |=> RMW_OPERAND == ($past(RMW_ADDR) == PORT_ADDR ? $past(PORT_PINS) : $past(FILE_RD_DATA)))
    else $error("wrong read-modify-write operand");
  a_long_store: assert property (
    TBL_WR_STB && TBL_LONG_REQ |=> TBL_WR_BUSY [*3] ##1 !TBL_WR_BUSY) else $error("long store");
  a_short_store: assert property (
    TBL_WR_STB && !TBL_LONG_REQ |=> !TBL_WR_BUSY && !TBL_WR_STB) else $error("short store");
  a_busy_no_strobe: assert property (TBL_WR_BUSY |-> !TBL_WR_STB) else $error("strobe in busy");
  a_kick_pulse: assert property (WDT_CLEAR |=> !WDT_CLEAR) else $error("kick pulse too long");
  a_wake_exit: assert property (STANDBY && WAKE |=> !STANDBY) else $error("standby held");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("b drop");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("r drop");
  c_long_store: cover property (TBL_WR_STB && TBL_LONG_REQ);
  c_wake: cover property (STANDBY && WAKE);
  c_prescaler: cover property (PRESCALER_CLEAR);
endmodule
bind cltd_core cltd_checker #(.TIMER_ZERO_ADDR(TIMER_ZERO_ADDR), .PORT_ADDR(PORT_ADDR))
  i_cltd_checker (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .TBL_WR_STB(TBL_WR_STB),
  .TBL_LONG_REQ(TBL_LONG_REQ), .TBL_WR_BUSY(TBL_WR_BUSY), .WDT_CLEAR(WDT_CLEAR),
  .STANDBY(STANDBY), .WAKE(WAKE), .FILE_WR_STB(FILE_WR_STB), .FILE_WR_ADDR(FILE_WR_ADDR),
  .FILE_WR_DEST(FILE_WR_DEST), .PRESCALER_ASSIGNED(PRESCALER_ASSIGNED),
  .PRESCALER_CLEAR(PRESCALER_CLEAR), .RMW_ADDR(RMW_ADDR), .PORT_PINS(PORT_PINS),
  .FILE_RD_DATA(FILE_RD_DATA), .RMW_OPERAND(RMW_OPERAND));

// ==== verif/tb_cltd_core.sv ====
// self-checking bench: runs the program image, then inspects state over AXI4-Lite
// assumes cltd_prog_mem holds an image that ends in standby and a spin loop
`timescale 1ns/10ps
module tb_cltd_core;
  logic REF_CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, TBL_RD_DATA, TBL_WR_DATA, PORT_PINS, FILE_RD_DATA;
  logic [7:0] RMW_OPERAND;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  logic [20:0] FETCH_ADDR, TBL_ADDR;
  logic [15:0] FETCH_WORD;
  logic TBL_WR_STB, TBL_LONG_REQ, TBL_WR_BUSY, WDT_CLEAR, STANDBY, WAKE;
  logic FILE_WR_STB, FILE_WR_DEST, PRESCALER_ASSIGNED, PRESCALER_CLEAR;
  logic [11:0] FILE_WR_ADDR, RMW_ADDR;
  int mismatches, num_checks, cycles, kicks, stores;
  logic [7:0] stored;
  logic [7:0] ra [10] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h2C, 8'h00};
  logic [31:0] rv [10] = '{32'h47, 32'h42, 32'h5, 32'h2, 32'h5A, 32'hAE, 32'h0, 32'h0, 32'h1BC, 32'h3};
  cltd_core i_cltd_core (.REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .FETCH_ADDR(FETCH_ADDR), .FETCH_WORD(FETCH_WORD),
    .TBL_ADDR(TBL_ADDR), .TBL_RD_DATA(TBL_RD_DATA), .TBL_WR_DATA(TBL_WR_DATA),
    .TBL_WR_STB(TBL_WR_STB), .TBL_LONG_REQ(TBL_LONG_REQ), .TBL_WR_BUSY(TBL_WR_BUSY),
    .WDT_CLEAR(WDT_CLEAR), .STANDBY(STANDBY), .WAKE(WAKE), .FILE_WR_STB(FILE_WR_STB),
    .FILE_WR_ADDR(FILE_WR_ADDR), .FILE_WR_DEST(FILE_WR_DEST),
    .PRESCALER_ASSIGNED(PRESCALER_ASSIGNED), .PRESCALER_CLEAR(PRESCALER_CLEAR),
    .RMW_ADDR(RMW_ADDR), .PORT_PINS(PORT_PINS), .FILE_RD_DATA(FILE_RD_DATA),
    .RMW_OPERAND(RMW_OPERAND));
  cltd_prog_mem i_cltd_prog_mem (.FETCH_ADDR(FETCH_ADDR), .FETCH_WORD(FETCH_WORD),
    .TBL_ADDR(TBL_ADDR), .TBL_RD_DATA(TBL_RD_DATA), .TBL_LONG_REQ(TBL_LONG_REQ));
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready only moves at rising edges, so the value at the falling edge is the one taken
  // response ready rises a cycle late so the slave must hold a waiting answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, up;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(negedge REF_CLK);
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      up = S_AXI_BVALID === 1'b1;
      tb = up && S_AXI_BREADY === 1'b1;
      resp = S_AXI_BRESP;
      @(posedge REF_CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      if (tb) S_AXI_BREADY <= 1'b0;
      else if (up) S_AXI_BREADY <= 1'b1;
    end while (!tb);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ta, tr, up;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(negedge REF_CLK);
      ta = S_AXI_ARVALID && S_AXI_ARREADY;
      up = S_AXI_RVALID === 1'b1;
      tr = up && S_AXI_RREADY === 1'b1;
      rd = S_AXI_RDATA;
      resp = S_AXI_RRESP;
      @(posedge REF_CLK);
      if (ta) S_AXI_ARVALID <= 1'b0;
      if (tr) S_AXI_RREADY <= 1'b0;
      else if (up) S_AXI_RREADY <= 1'b1;
    end while (!tr);
  endtask
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  always @(negedge REF_CLK) if (WDT_CLEAR === 1'b1) kicks++;
  always @(negedge REF_CLK) begin
    if (TBL_WR_STB === 1'b1) begin
      stores++;
      stored = TBL_WR_DATA;
    end
  end
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, WAKE, FILE_WR_STB, FILE_WR_DEST} = '0;
    {FILE_WR_ADDR, RMW_ADDR, PORT_PINS, FILE_RD_DATA, PRESCALER_ASSIGNED} = '0;
    S_AXI_WSTRB = 4'hF;
    RST = 1'b1;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 300 && STANDBY !== 1'b1; i++) @(negedge REF_CLK);
    check(STANDBY, 32'h1);
    check(kicks, 32'h1);
    check(stores, 32'h2);
    check(stored, 32'h5A);
    axi_rd(8'h04);
    check(rd, 32'hC7);
    @(posedge REF_CLK);
    WAKE <= 1'b1;
    @(posedge REF_CLK);
    @(negedge REF_CLK);
    check(STANDBY, 32'h0);
    @(posedge REF_CLK);
    WAKE <= 1'b0;
    // status, W, bank, pointer, latch, product, stack, top of stack, indirect pointer 1, control
    for (int i = 0; i < 10; i++) begin
      axi_rd(ra[i]);
      check(rd, rv[i]);
    end
    axi_wr(8'h18, 32'hAB);
    axi_rd(8'h18);
    check(rd, 32'hAB);
    axi_wr(8'h08, 32'h11);
    check(resp, cltd_pkg::RESP_OKAY);
    axi_rd(8'h08);
    check(rd, 32'h42);
    axi_wr(8'h40, 32'h1);
    check(resp, cltd_pkg::RESP_SLVERR);
    axi_rd(8'h40);
    check(rd, 32'h0);
    check(resp, cltd_pkg::RESP_SLVERR);
    // first case hits the timer with prescaler assigned, second leaves it unassigned
    for (int i = 0; i < 2; i++) begin
      @(posedge REF_CLK);
      FILE_WR_STB <= 1'b1;
      FILE_WR_ADDR <= 12'h0F0;
      FILE_WR_DEST <= 1'b1;
      PRESCALER_ASSIGNED <= (i == 0);
      RMW_ADDR <= (i == 0) ? 12'h0F1 : 12'h0F0;
      PORT_PINS <= 8'h3C;
      FILE_RD_DATA <= 8'hC3;
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      check(PRESCALER_CLEAR, (i == 0) ? 32'h1 : 32'h0);
      check(RMW_OPERAND, (i == 0) ? 32'h3C : 32'hC3);
    end
    report_and_stop();
  end
endmodule
